// file: core/adc_ctrl_pkg.sv
// Purpose: shared constants and types for the converter control and result logic
// Assumes: 8-bit register port, one system clock, analog core on the far side
// Notes: offsets are byte addresses on the register port
package adc_ctrl_pkg;
  localparam logic [7:0] RESULT_LOW_OFFSET = 8'h78;
  localparam logic [7:0] RESULT_HIGH_OFFSET = 8'h79;
  localparam logic [7:0] CTRL_STATUS_A_OFFSET = 8'h7A;
  localparam logic [7:0] TRIG_SELECT_OFFSET = 8'h7B;
  localparam logic [7:0] INPUT_SELECT_OFFSET = 8'h7C;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // control and status a layout
  localparam int ENABLE_BIT = 7;
  localparam int START_BIT = 6;
  localparam int AUTO_TRIG_BIT = 5;
  localparam int DONE_FLAG_BIT = 4;
  localparam int IRQ_EN_BIT = 3;
  localparam int PRESCALE_MSB = 2;
  localparam int PRESCALE_LSB = 0;

  // input select and trigger select layout
  localparam int VREF_MSB = 7;
  localparam int VREF_LSB = 6;
  localparam int LEFT_ALIGN_BIT = 5;
  localparam int CHANNEL_MSB = 4;
  localparam int CHANNEL_LSB = 0;
  localparam int TRIG_SRC_MSB = 2;
  localparam int TRIG_SRC_LSB = 0;

  localparam logic [7:0] CTRL_STATUS_A_RESET = 8'h00;
  localparam logic [7:0] INPUT_SELECT_RESET = 8'h00;
  localparam logic [2:0] TRIG_SELECT_RESET = 3'h0;
  localparam logic [2:0] TRIG_FREE_RUNNING = 3'h0;

  localparam logic [1:0] VREF_EXT_PIN = 2'h0;
  localparam logic [1:0] VREF_ANALOG_SUPPLY = 2'h1;
  localparam logic [1:0] VREF_RESERVED = 2'h2;
  localparam logic [1:0] VREF_INTERNAL = 2'h3;

  // analog multiplexer selections
  localparam logic [3:0] POS_BANDGAP = 4'h8;
  localparam logic [3:0] POS_GROUND = 4'h9;
  localparam logic [3:0] POS_NONE = 4'hF;
  localparam logic [1:0] NEG_NONE = 2'h0;
  localparam logic [1:0] NEG_INPUT1 = 2'h1;
  localparam logic [1:0] NEG_INPUT2 = 2'h2;
  localparam logic [1:0] CHAN_GRP_SINGLE = 2'h0;
  localparam logic [1:0] CHAN_GRP_RESERVED = 2'h1;
  localparam logic [1:0] CHAN_GRP_NEG1 = 2'h2;
  localparam logic [2:0] CHAN_BANDGAP_LOW = 3'h6;
  localparam logic [2:0] CHAN_GROUND_LOW = 3'h7;

  // raw core code is input difference times 1024 over reference
  localparam int RAW_WIDTH = 12;
  localparam int RESULT_WIDTH = 10;
  localparam logic signed [11:0] SE_CODE_MIN = 12'sh000;
  localparam logic signed [11:0] SE_CODE_MAX = 12'sh3FF;
  localparam logic signed [11:0] DIFF_CODE_MAX = 12'sh1FF;
  localparam logic signed [11:0] DIFF_CODE_MIN = 12'shE00;

  localparam logic [4:0] FIRST_CONV_CYCLES = 5'd25;
  localparam logic [4:0] NORMAL_CONV_CYCLES = 5'd13;
  localparam logic [4:0] COUNT_STEP = 5'h01;
  localparam logic [7:0] PRESCALE_MIN_DIV = 8'h02;
  localparam logic [7:0] PRESCALE_ONE = 8'h01;
  localparam logic [2:0] PRESCALE_CODE_ZERO = 3'h0;

  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_IDLE = 3'b010,
    ST_CONV = 3'b100
  } conv_state_type;
endpackage

// file: core/adc_clock_divider.sv
// Purpose: converter clock enable derived from the system clock
// Assumes: sel_in comes from a register on the same clock
// Notes: tick_out is a one-cycle enable, never a clock
`timescale 1ns/1ps
`default_nettype none
module adc_clock_divider (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  input wire logic [2:0] sel_in,
  output logic tick_out
);
  logic [7:0] divisor;
  logic [7:0] limit;
  logic [7:0] count;

  always_comb
  begin
    if (sel_in == adc_ctrl_pkg::PRESCALE_CODE_ZERO)
      divisor = adc_ctrl_pkg::PRESCALE_MIN_DIV;
    else
      divisor = adc_ctrl_pkg::PRESCALE_ONE << sel_in;
    limit = divisor - adc_ctrl_pkg::PRESCALE_ONE;
  end

  // >= so a smaller divisor written mid-period cannot strand the count
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      count <= 8'h00;
      tick_out <= 1'b0;
    end
    else if (!run_in)
    begin
      count <= 8'h00;
      tick_out <= 1'b0;
    end
    else if (count >= limit)
    begin
      count <= 8'h00;
      tick_out <= 1'b1;
    end
    else
    begin
      count <= count + adc_ctrl_pkg::PRESCALE_ONE;
      tick_out <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// file: core/adc_result_and_control.sv
// Purpose: control, timing and result registers of a 10-bit converter
// Assumes: core_raw_in is settled when the last converter clock of a conversion ends
// Notes: trigger flags come from peripherals on the same clock, so no synchroniser
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module adc_result_and_control (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [7:0] rdata_out,
  output logic irq_out,
  input wire logic irq_ack_in,
  input wire logic [6:0] trig_flags_in,
  input wire logic signed [11:0] core_raw_in,
  output logic core_power_out,
  output logic core_run_out,
  output logic core_init_out,
  output logic core_tick_out,
  output logic [1:0] vref_select_out,
  output logic int_ref_on_out,
  output logic [3:0] mux_pos_out,
  output logic [1:0] mux_neg_out,
  output logic diff_mode_out
);
  adc_ctrl_pkg::conv_state_type state;
  logic conv_enable;
  logic auto_trig_en;
  logic conv_done_flag;
  logic conv_done_irq_en;
  logic [2:0] clk_prescale_sel;
  logic [2:0] trig_source_sel;
  logic [1:0] vref_select;
  logic left_align;
  logic [4:0] channel_select;
  logic [9:0] result;
  logic read_lock;
  logic first_pending;
  logic [4:0] tick_count;
  logic trig_prev;
  logic done_d;
  logic tick;
  logic wr_ctrl;
  logic wr_input;
  logic wr_trig;
  logic next_enable;
  logic busy;
  logic trig_level;
  logic trig_start;
  logic start_go;
  logic launch;
  logic done_event;
  logic [4:0] conv_length;
  logic [7:0] low_byte;
  logic [7:0] high_byte;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  // clamp the raw core code to the documented code ranges
  function automatic logic [9:0] encode(input logic signed [11:0] raw, input logic diff);
    logic signed [11:0] half;
    half = raw >>> 1;
    if (!diff)
    begin
      if (raw < adc_ctrl_pkg::SE_CODE_MIN)
        encode = adc_ctrl_pkg::SE_CODE_MIN[9:0];
      else if (raw > adc_ctrl_pkg::SE_CODE_MAX)
        encode = adc_ctrl_pkg::SE_CODE_MAX[9:0];
      else
        encode = raw[9:0];
    end
    else
    begin
      if (half > adc_ctrl_pkg::DIFF_CODE_MAX)
        encode = adc_ctrl_pkg::DIFF_CODE_MAX[9:0];
      else if (half < adc_ctrl_pkg::DIFF_CODE_MIN)
        encode = adc_ctrl_pkg::DIFF_CODE_MIN[9:0];
      else
        encode = half[9:0];
    end
  endfunction

  // returns {diff, positive select, negative select}
  function automatic logic [6:0] decode_chan(input logic [4:0] chan);
    logic [1:0] grp;
    grp = chan[4:3];
    if (grp == adc_ctrl_pkg::CHAN_GRP_SINGLE)
      decode_chan = {1'b0, 1'b0, chan[2:0], adc_ctrl_pkg::NEG_NONE};
    else if (grp == adc_ctrl_pkg::CHAN_GRP_RESERVED)
      decode_chan = {1'b0, adc_ctrl_pkg::POS_NONE, adc_ctrl_pkg::NEG_NONE};
    else if (grp == adc_ctrl_pkg::CHAN_GRP_NEG1)
      decode_chan = {1'b1, 1'b0, chan[2:0], adc_ctrl_pkg::NEG_INPUT1};
    else if (chan[2:0] == adc_ctrl_pkg::CHAN_BANDGAP_LOW)
      decode_chan = {1'b0, adc_ctrl_pkg::POS_BANDGAP, adc_ctrl_pkg::NEG_NONE};
    else if (chan[2:0] == adc_ctrl_pkg::CHAN_GROUND_LOW)
      decode_chan = {1'b0, adc_ctrl_pkg::POS_GROUND, adc_ctrl_pkg::NEG_NONE};
    else
      decode_chan = {1'b1, 1'b0, chan[2:0], adc_ctrl_pkg::NEG_INPUT2};
  endfunction

  adc_clock_divider divider (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .run_in(conv_enable),
    .sel_in(clk_prescale_sel),
    .tick_out(tick)
  );

  assign wr_ctrl = wr_in & hit(addr_in, adc_ctrl_pkg::CTRL_STATUS_A_OFFSET);
  assign wr_input = wr_in & hit(addr_in, adc_ctrl_pkg::INPUT_SELECT_OFFSET);
  assign wr_trig = wr_in & hit(addr_in, adc_ctrl_pkg::TRIG_SELECT_OFFSET);
  // enabling and starting in one write must start the conversion
  assign next_enable = wr_ctrl ? wdata_in[adc_ctrl_pkg::ENABLE_BIT] : conv_enable;
  assign busy = (state == adc_ctrl_pkg::ST_CONV);

  always_comb
  begin
    if (trig_source_sel == adc_ctrl_pkg::TRIG_FREE_RUNNING)
      trig_level = 1'b0;
    else
      trig_level = trig_flags_in[trig_source_sel - 3'h1];
  end

  // free running restarts off the previous completion, not off a flag level
  assign trig_start = auto_trig_en &
    ((trig_level & ~trig_prev) |
     (done_d & (trig_source_sel == adc_ctrl_pkg::TRIG_FREE_RUNNING)));
  // only a written one starts; a zero is no request at all
  assign start_go = next_enable &
    ((wr_ctrl & wdata_in[adc_ctrl_pkg::START_BIT]) | trig_start);
  assign launch = start_go & ~busy;
  assign conv_length = core_init_out ? adc_ctrl_pkg::FIRST_CONV_CYCLES :
    adc_ctrl_pkg::NORMAL_CONV_CYCLES;
  assign done_event = busy & next_enable & tick &
    (tick_count == conv_length - adc_ctrl_pkg::COUNT_STEP);

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      state <= adc_ctrl_pkg::ST_OFF;
    else
    begin
      unique case (state)
        adc_ctrl_pkg::ST_OFF:
        begin
          if (launch)
            state <= adc_ctrl_pkg::ST_CONV;
          else if (next_enable)
            state <= adc_ctrl_pkg::ST_IDLE;
        end
        adc_ctrl_pkg::ST_IDLE:
        begin
          if (!next_enable)
            state <= adc_ctrl_pkg::ST_OFF;
          else if (launch)
            state <= adc_ctrl_pkg::ST_CONV;
        end
        adc_ctrl_pkg::ST_CONV:
        begin
          if (!next_enable)
            state <= adc_ctrl_pkg::ST_OFF;
          else if (done_event)
            state <= adc_ctrl_pkg::ST_IDLE;
        end
        default:
          state <= adc_ctrl_pkg::ST_OFF;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tick_count <= 5'h00;
      core_init_out <= 1'b0;
    end
    else if (launch)
    begin
      tick_count <= 5'h00;
      core_init_out <= first_pending;
    end
    else if (busy & tick)
      tick_count <= tick_count + adc_ctrl_pkg::COUNT_STEP;
  end

  // the start that launches wins over re-arming, so enable plus start is long
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      first_pending <= 1'b1;
    else if (launch)
      first_pending <= 1'b0;
    else if (!conv_enable)
      first_pending <= 1'b1;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      trig_prev <= 1'b0;
      done_d <= 1'b0;
    end
    else
    begin
      trig_prev <= trig_level;
      done_d <= done_event;
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      conv_enable <= adc_ctrl_pkg::CTRL_STATUS_A_RESET[adc_ctrl_pkg::ENABLE_BIT];
      auto_trig_en <= adc_ctrl_pkg::CTRL_STATUS_A_RESET[adc_ctrl_pkg::AUTO_TRIG_BIT];
      conv_done_irq_en <= adc_ctrl_pkg::CTRL_STATUS_A_RESET[adc_ctrl_pkg::IRQ_EN_BIT];
      clk_prescale_sel <=
        adc_ctrl_pkg::CTRL_STATUS_A_RESET[adc_ctrl_pkg::PRESCALE_MSB:adc_ctrl_pkg::PRESCALE_LSB];
    end
    else if (wr_ctrl)
    begin
      conv_enable <= wdata_in[adc_ctrl_pkg::ENABLE_BIT];
      auto_trig_en <= wdata_in[adc_ctrl_pkg::AUTO_TRIG_BIT];
      conv_done_irq_en <= wdata_in[adc_ctrl_pkg::IRQ_EN_BIT];
      clk_prescale_sel <= wdata_in[adc_ctrl_pkg::PRESCALE_MSB:adc_ctrl_pkg::PRESCALE_LSB];
    end
  end

  // a completion in the clearing cycle keeps the flag set
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      conv_done_flag <= 1'b0;
    else if (done_event)
      conv_done_flag <= 1'b1;
    else if ((wr_ctrl & wdata_in[adc_ctrl_pkg::DONE_FLAG_BIT]) | irq_ack_in)
      conv_done_flag <= 1'b0;
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      vref_select <= adc_ctrl_pkg::INPUT_SELECT_RESET[adc_ctrl_pkg::VREF_MSB:adc_ctrl_pkg::VREF_LSB];
      left_align <= adc_ctrl_pkg::INPUT_SELECT_RESET[adc_ctrl_pkg::LEFT_ALIGN_BIT];
      channel_select <=
        adc_ctrl_pkg::INPUT_SELECT_RESET[adc_ctrl_pkg::CHANNEL_MSB:adc_ctrl_pkg::CHANNEL_LSB];
    end
    else if (wr_input)
    begin
      vref_select <= wdata_in[adc_ctrl_pkg::VREF_MSB:adc_ctrl_pkg::VREF_LSB];
      left_align <= wdata_in[adc_ctrl_pkg::LEFT_ALIGN_BIT];
      channel_select <= wdata_in[adc_ctrl_pkg::CHANNEL_MSB:adc_ctrl_pkg::CHANNEL_LSB];
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      trig_source_sel <= adc_ctrl_pkg::TRIG_SELECT_RESET;
    else if (wr_trig)
      trig_source_sel <= wdata_in[adc_ctrl_pkg::TRIG_SRC_MSB:adc_ctrl_pkg::TRIG_SRC_LSB];
  end

  // analog selections freeze while converting so a mid-conversion write waits
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      vref_select_out <= adc_ctrl_pkg::VREF_EXT_PIN;
      int_ref_on_out <= 1'b0;
      {diff_mode_out, mux_pos_out, mux_neg_out} <= {1'b0, 4'h0, adc_ctrl_pkg::NEG_NONE};
    end
    else if (!busy)
    begin
      vref_select_out <= vref_select;
      int_ref_on_out <= (vref_select == adc_ctrl_pkg::VREF_INTERNAL);
      {diff_mode_out, mux_pos_out, mux_neg_out} <= decode_chan(channel_select);
    end
  end

  // a held-off result is dropped; the flag still reports the completion
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      result <= 10'h000;
    else if (done_event & ~read_lock)
      result <= encode(core_raw_in, diff_mode_out);
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      read_lock <= 1'b0;
    else if (rd_in & hit(addr_in, adc_ctrl_pkg::RESULT_HIGH_OFFSET))
      read_lock <= 1'b0;
    else if (rd_in & hit(addr_in, adc_ctrl_pkg::RESULT_LOW_OFFSET))
      read_lock <= 1'b1;
  end

  always_comb
  begin
    if (left_align)
    begin
      high_byte = result[9:2];
      low_byte = {result[1:0], 6'h00};
    end
    else
    begin
      high_byte = {6'h00, result[9:8]};
      low_byte = result[7:0];
    end
  end

  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      rdata_out <= adc_ctrl_pkg::READ_UNMAPPED;
    else if (!rd_in)
      rdata_out <= adc_ctrl_pkg::READ_UNMAPPED;
    else if (hit(addr_in, adc_ctrl_pkg::RESULT_LOW_OFFSET))
      rdata_out <= low_byte;
    else if (hit(addr_in, adc_ctrl_pkg::RESULT_HIGH_OFFSET))
      rdata_out <= high_byte;
    else if (hit(addr_in, adc_ctrl_pkg::CTRL_STATUS_A_OFFSET))
      rdata_out <= {conv_enable, busy, auto_trig_en, conv_done_flag,
        conv_done_irq_en, clk_prescale_sel};
    else if (hit(addr_in, adc_ctrl_pkg::INPUT_SELECT_OFFSET))
      rdata_out <= {vref_select, left_align, channel_select};
    else if (hit(addr_in, adc_ctrl_pkg::TRIG_SELECT_OFFSET))
      rdata_out <= {5'h00, trig_source_sel};
    else
      rdata_out <= adc_ctrl_pkg::READ_UNMAPPED;
  end

  assign irq_out = conv_done_flag & conv_done_irq_en;
  assign core_power_out = conv_enable;
  assign core_run_out = busy;
  assign core_tick_out = tick;
endmodule
`default_nettype wire

// file: test/adc_ctrl_properties.sv
// Purpose: port-level assertions for the converter control block
// Assumes: bound to adc_result_and_control, one clock domain
// Notes: conversion length counted in converter ticks while busy
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_checker (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic irq_out,
  input wire logic irq_ack_in,
  input wire logic core_power_out,
  input wire logic core_run_out,
  input wire logic core_init_out,
  input wire logic core_tick_out,
  input wire logic [1:0] vref_select_out,
  input wire logic int_ref_on_out,
  input wire logic [3:0] mux_pos_out,
  input wire logic [1:0] mux_neg_out,
  input wire logic diff_mode_out
);
  logic [5:0] tick_cnt;
  logic ctrl_wr;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  assign ctrl_wr = wr_in && addr_in == 8'h7A;
  // holds its final count for one cycle after busy drops
  always_ff @(posedge ref_clk_in or posedge rst_in)
  begin
    if (rst_in)
      tick_cnt <= 6'h00;
    else if (!core_run_out)
      tick_cnt <= 6'h00;
    else
      tick_cnt <= tick_cnt + {5'h00, core_tick_out};
  end
  chk_power_follow: assert property (ctrl_wr |=> core_power_out == $past(wdata_in[7]))
    else $error("enable output differs from written bit");
  chk_abort_stop: assert property (core_run_out && ctrl_wr && !wdata_in[7] |=> !core_run_out)
    else $error("conversion kept running after disable");
  chk_zero_start: assert property (
    core_run_out && !core_tick_out && ctrl_wr && wdata_in[7:6] == 2'h2 |=> core_run_out)
    else $error("zero start write disturbed conversion");
  chk_off_idle: assert property (!core_power_out && !(ctrl_wr && wdata_in[7]) |=> !core_run_out)
    else $error("conversion started while disabled");
  chk_conv_len: assert property (
    $fell(core_run_out) && core_power_out |-> tick_cnt == ($past(core_init_out) ? 6'd25 : 6'd13))
    else $error("conversion tick count wrong");
  chk_busy_read: assert property (
    $past(rd_in) && $past(addr_in) == 8'h7A |-> rdata_out[6] == $past(core_run_out))
    else $error("start bit readback differs from busy");
  chk_rd_idle: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
    else $error("read data outside its cycle");
  chk_irq_ack: assert property (irq_ack_in && !core_run_out |=> !irq_out)
    else $error("interrupt stayed after acknowledge");
  chk_sel_freeze: assert property (core_run_out && $past(core_run_out) |->
    $stable(mux_pos_out) && $stable(mux_neg_out) && $stable(vref_select_out))
    else $error("selection changed during conversion");
  chk_int_ref: assert property (int_ref_on_out == (vref_select_out == 2'h3))
    else $error("internal reference enable mismatch");
  chk_diff_neg: assert property (diff_mode_out == (mux_neg_out != 2'h0))
    else $error("differential mode and negative input disagree");
endmodule
bind adc_result_and_control adc_ctrl_checker u_adc_ctrl_checker (
  .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
  .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
  .irq_ack_in(irq_ack_in), .core_power_out(core_power_out), .core_run_out(core_run_out),
  .core_init_out(core_init_out), .core_tick_out(core_tick_out),
  .vref_select_out(vref_select_out), .int_ref_on_out(int_ref_on_out),
  .mux_pos_out(mux_pos_out), .mux_neg_out(mux_neg_out), .diff_mode_out(diff_mode_out)
);
`default_nettype wire

// file: test/adc_core_model.sv
// Purpose: behavioural analog core giving raw codes for the selected inputs
// Assumes: input n sits at n*0xC3 codes, bandgap at 0x1C0, ground at zero
// Notes: outside a conversion the code is inverted so stale values never match
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
  input wire logic core_run_in,
  input wire logic [3:0] mux_pos_in,
  input wire logic [1:0] mux_neg_in,
  output logic signed [11:0] core_raw_out
);
  logic signed [11:0] pos_level, raw;
  always_comb
  begin
    pos_level = 12'sh000;
    if (mux_pos_in < 4'h8)
      pos_level = $signed({8'h00, mux_pos_in}) * 12'sh0C3;
    else if (mux_pos_in == 4'h8)
      pos_level = 12'sh1C0;
    raw = pos_level - $signed({10'h000, mux_neg_in}) * 12'sh0C3;
  end
  assign core_raw_out = core_run_in ? raw : ~raw;
endmodule
`default_nettype wire

// file: test/tb_top.sv
// Purpose: directed tests of the converter control and result block
// Assumes: analog core model on the core side, small prescale codes
// Notes: each scenario task checks its own results before returning
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin num_errors++; \
  $display("BAD t=%0t got %h exp %h", $time, got, exp); end end
module tb_top;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic irq_ack_in = 1'b0;
  logic [6:0] trig_flags_in = 7'h00;
  logic signed [11:0] core_raw_in;
  logic [7:0] rdata_out;
  logic irq_out, core_power_out, core_run_out, core_init_out, core_tick_out;
  logic int_ref_on_out, diff_mode_out;
  logic [1:0] vref_select_out, mux_neg_out;
  logic [3:0] mux_pos_out;
  int num_errors = 0;
  int cmp_count = 0;
  int n;
  adc_result_and_control u_adc_result_and_control (
    .ref_clk_in(ref_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
    .irq_ack_in(irq_ack_in), .trig_flags_in(trig_flags_in), .core_raw_in(core_raw_in),
    .core_power_out(core_power_out), .core_run_out(core_run_out),
    .core_init_out(core_init_out), .core_tick_out(core_tick_out),
    .vref_select_out(vref_select_out), .int_ref_on_out(int_ref_on_out),
    .mux_pos_out(mux_pos_out), .mux_neg_out(mux_neg_out), .diff_mode_out(diff_mode_out)
  );
  adc_core_model u_adc_core_model (.core_run_in(core_run_out), .mux_pos_in(mux_pos_out),
    .mux_neg_in(mux_neg_out), .core_raw_out(core_raw_in));
  always #50 ref_clk_in = ~ref_clk_in;
  task automatic finish_test;
    $display("errors %0d compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 `CHK(rdata_out, exp)
  endtask
  // bounded so a stuck busy cannot hang the run
  task automatic wait_run(input logic v);
    n = 0;
    do
    begin
      @(posedge ref_clk_in);
      #1 n++;
    end
    while (core_run_out !== v && n < 2000);
    `CHK(core_run_out, v)
  endtask
  task automatic conv(input logic [7:0] sel, input logic [7:0] ctrl, input int t, input int d,
    input logic [15:0] exp);
    wr(8'h7C, sel);
    wr(8'h7A, ctrl);
    wait_run(1'b0);
    // free-running divider: a tick in the launch cycle is not counted, the first counted one comes 1 to d cycles later, d+1 if that write enables
    `CHK(n >= (t - 1) * d + 1 && n <= t * d + 1, 1'b1)
    `CHK(core_run_out, 1'b0)
    rd(8'h78, exp[7:0]);
    rd(8'h79, exp[15:8]);
  endtask
  task automatic t_reset;
    for (int a = 8'h78; a <= 8'h7C; a++)
      rd(8'(a), 8'h00);
    wr(8'h55, 8'hFF);
    rd(8'h55, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_select;
    logic [4:0] codes [8] = '{5'h00, 5'h07, 5'h10, 5'h17, 5'h18, 5'h1D, 5'h1E, 5'h1F};
    logic [4:0] c;
    for (int i = 0; i < 8; i++)
    begin
      c = codes[i];
      wr(8'h7C, {2'(i), 1'b0, c});
      @(posedge ref_clk_in);
      #1 `CHK(vref_select_out, 2'(i))
      `CHK(int_ref_on_out, 2'(i) == 2'h3)
      `CHK(mux_pos_out, (c[4:1] == 4'hF) ? {3'h4, c[0]} : {1'b0, c[2:0]})
      `CHK(mux_neg_out, (c[4] && c[4:1] != 4'hF) ? {c[3], ~c[3]} : 2'h0)
      `CHK(diff_mode_out, c[4] && c[4:1] != 4'hF)
    end
    wr(8'h7C, 8'h0A);
    @(posedge ref_clk_in);
    #1 `CHK(mux_pos_out, 4'hF)
    `CHK(diff_mode_out, 1'b0)
    $display("test select done");
  endtask
  task automatic t_single;
    conv(8'h43, 8'hC8, 25, 2, 16'h0249);
    rd(8'h7A, 8'h98);
    `CHK(irq_out, 1'b1)
    @(posedge ref_clk_in);
    irq_ack_in <= 1'b1;
    @(posedge ref_clk_in);
    irq_ack_in <= 1'b0;
    #1 `CHK(irq_out, 1'b0)
    conv(8'h47, 8'hDB, 13, 8, 16'h03FF);
    wr(8'h7A, 8'h93);
    rd(8'h7A, 8'h83);
    conv(8'h70, 8'hD8, 13, 2, 16'hE780);
    wr(8'h7C, 8'h50);
    rd(8'h78, 8'h9E);
    rd(8'h79, 8'h03);
    conv(8'h57, 8'hD8, 13, 2, 16'h01FF);
    conv(8'h5E, 8'hD8, 13, 2, 16'h01C0);
    conv(8'h5F, 8'hD8, 13, 2, 16'h0000);
    conv(8'h43, 8'hD9, 13, 2, 16'h0249);
    $display("test single done");
  endtask
  task automatic t_defer;
    wr(8'h7C, 8'h43);
    wr(8'h7A, 8'hD8);
    wr(8'h7C, 8'h47);
    wr(8'h7A, 8'h88);
    #1 `CHK(core_run_out, 1'b1)
    wait_run(1'b0);
    rd(8'h78, 8'h49);
    rd(8'h79, 8'h02);
    `CHK(mux_pos_out, 4'h7)
    rd(8'h78, 8'h49);
    conv(8'h47, 8'hD8, 13, 2, 16'h0249);
    conv(8'h47, 8'hD8, 13, 2, 16'h03FF);
    $display("test defer done");
  endtask
  task automatic t_auto;
    wr(8'h7B, 8'h00);
    wr(8'h7A, 8'hF0);
    for (int i = 0; i < 2; i++)
    begin
      wait_run(1'b0);
      wait_run(1'b1);
      `CHK(n <= 3, 1'b1)
    end
    wr(8'h7A, 8'h10);
    #1 `CHK(core_run_out, 1'b0)
    rd(8'h7A, 8'h00);
    wr(8'h7B, 8'h01);
    wr(8'h7A, 8'hA0);
    @(posedge ref_clk_in);
    trig_flags_in <= 7'h01;
    wait_run(1'b1);
    `CHK(n <= 3, 1'b1)
    wait_run(1'b0);
    // level held high: no further edge, so no relaunch
    repeat (6) @(posedge ref_clk_in);
    #1 `CHK(core_run_out, 1'b0)
    @(posedge ref_clk_in);
    trig_flags_in <= 7'h04;
    wr(8'h7B, 8'h03);
    wait_run(1'b1);
    `CHK(n <= 3, 1'b1)
    wait_run(1'b0);
    wr(8'h7A, 8'h30);
    @(posedge ref_clk_in);
    trig_flags_in <= 7'h00;
    @(posedge ref_clk_in);
    trig_flags_in <= 7'h04;
    wr(8'h7A, 8'h60);
    rd(8'h7A, 8'h20);
    `CHK(core_run_out, 1'b0)
    $display("test auto done");
  endtask
  initial
  begin
    repeat (12) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_select();
    t_single();
    t_defer();
    t_auto();
    finish_test();
  end
  // whole run needs well under 2000 cycles
  initial
  begin
    #2000000;
    num_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
